// ---- hw/pfc_regs.svh ----
// Constants of the parallel flash configuration loader
`ifndef PFC_REGS_SVH
`define PFC_REGS_SVH
// System clock period in picoseconds
`define PFC_CLK_PS 4000
// Flash bus clock: typical and longest allowed period
`define PFC_FCLK_TYP_PS 33330
`define PFC_FCLK_MAX_PS 50000
// Cycles per flash clock period; rounded down stays below the typical
`define PFC_FCLK_CYC (`PFC_FCLK_TYP_PS / `PFC_CLK_PS)
`define PFC_FCLK_HALF (`PFC_FCLK_CYC / 2)
// Default boot address, word view and byte view
`define PFC_BOOT_WORD_ADDR 24'h010000
`define PFC_BOOT_BYTE_ADDR 25'h0020000
// Initialization cycles after the completion line rises
`define PFC_INIT_CYCLES 12'hC71
// Longest reset time-out after an error
`define PFC_RESTART_US 230
// Boundary-scan data register layout
`define PFC_SR_W 40
`define PFC_SR_ADDR_LSB 0
`define PFC_SR_DATA_LSB 24
`endif

// ---- hw/pfc_pkg.sv ----
// Types of the parallel flash configuration loader
package pfc_pkg;
    typedef enum logic [2:0] {
        PFC_RESET,
        PFC_LOAD,
        PFC_WAIT_DONE,
        PFC_INIT,
        PFC_USER,
        PFC_ERROR
    } pfc_state_e;
    typedef logic [23:0] pfc_addr_t;
    typedef logic [15:0] pfc_word_t;
endpackage : pfc_pkg

// ---- hw/pfc_loader.sv ----
// Active-parallel configuration master with chain and scan control
`timescale 1ns/10ps
`include "pfc_regs.svh"

// Contract
// RQ1: Own data complete: enable next device, release completion line.
// RQ2: Enter initialization when the shared completion line rises high.
// RQ3: On a configuration error, drive the shared error line low.
// RQ4: With auto restart, reconfigure the chain within 230 us of an error.
// RQ5: Without auto restart, the outside controller pulses reset request low.
// RQ6: A second master holds reset request low 500 ns and drives chain select.
// RQ7: Held in reset, the flash bus outputs go high impedance.
// RQ8: Second master frees bus, then chain select, then pulses reset request.
// RQ9: Chain select level decides who owns the flash bus.
// RQ10: Flash clock from internal oscillator, period at most 50 ns.
// RQ11: Flash clock typical period is 33.33 ns; the divider gives 8 clock cycles, 32 ns.
// RQ12: One 16-bit word crosses the data bus per flash clock cycle.
// RQ13: Default start is word address 0x010000, byte address 0x020000.
// RQ14: A boundary-scan instruction replaces the start address.
// RQ15: The flash ready pin is ignored during configuration.
// RQ16: Flash can be programmed in system through the boundary-scan port.
// RQ17: Completed device drives its chain-enable output low.
// RQ18: Initialization takes 3185 cycles before user mode.
// RQ19: Reset request low resets, pulls both lines low, tri-states pins.
// RQ20: Word address starts at boot address and steps by one per word.
module pfc_loader
    import pfc_pkg::*;
#(
    parameter int RESTART_CYCLES =
        (`PFC_RESTART_US * 1000 * 1000) / `PFC_CLK_PS
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic config_reset_req_b,
    input wire logic chain_select_in,
    output logic chain_select_out_b,
    input wire logic config_complete_line_in,
    output logic config_complete_line_out,
    output logic config_complete_line_oe,
    input wire logic status_line_in,
    output logic status_line_out,
    output logic status_line_oe,
    output logic flash_bus_clock,
    output pfc_addr_t flash_addr,
    output logic flash_ce_b,
    output logic flash_oe_b,
    output logic flash_we_b,
    output logic flash_bus_oe,
    input wire pfc_word_t flash_data_in,
    output pfc_word_t flash_data_out,
    output logic flash_data_oe,
    input wire logic flash_ready,
    input wire logic auto_restart_en,
    output pfc_word_t cfg_word,
    output logic cfg_word_valid,
    input wire logic cfg_data_complete,
    input wire logic cfg_frame_error,
    output logic user_mode,
    input wire logic tck,
    input wire logic tdi,
    output logic tdo,
    input wire logic scan_shift,
    input wire logic scan_update,
    input wire logic scan_sel_boot,
    input wire logic scan_sel_isp
);
    localparam logic [3:0] FCLK_LAST = 4'(`PFC_FCLK_CYC - 1);
    localparam logic [3:0] FCLK_HALF = 4'(`PFC_FCLK_HALF);
    localparam logic [16:0] RESTART_LAST = 17'(RESTART_CYCLES - 1);

    pfc_state_e state;
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    pfc_word_t data_meta;
    pfc_word_t data_sync;
    logic req_s;
    logic csel_s;
    logic done_s;
    logic stat_s;
    logic [3:0] phase;
    logic phase_end;
    pfc_addr_t boot_addr;
    logic own_err;
    logic [16:0] restart_cnt;
    logic [11:0] init_cnt;
    logic isp_busy;
    logic [`PFC_SR_W-1:0] scan_sr;
    logic boot_tgl;
    logic isp_tgl;
    logic [2:0] boot_sync;
    logic [2:0] isp_sync;
    logic boot_load;
    logic isp_start;
    logic bus_run;

    // Ready pin is deliberately never sampled
    logic unused_ready;
    assign unused_ready = flash_ready; // RQ15

    // Pins come from outside the clock domain
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
            data_meta <= 16'h0000;
            data_sync <= 16'h0000;
        end else begin
            pin_meta <= {config_reset_req_b, chain_select_in,
                         config_complete_line_in, status_line_in};
            pin_sync <= pin_meta;
            data_meta <= flash_data_in;
            data_sync <= data_meta;
        end
    end
    assign req_s = pin_sync[3];
    assign csel_s = pin_sync[2];
    assign done_s = pin_sync[1];
    assign stat_s = pin_sync[0];

    // Scan side: shift register and update toggles on the scan clock
    always_ff @(posedge tck or negedge rst_b) begin
        if (!rst_b) begin
            scan_sr <= '0;
            boot_tgl <= 1'b0;
            isp_tgl <= 1'b0;
        end else begin
            if (scan_shift) begin
                scan_sr <= {tdi, scan_sr[`PFC_SR_W-1:1]};
            end
            if (scan_update && scan_sel_boot) begin
                boot_tgl <= ~boot_tgl; // RQ14
            end
            if (scan_update && scan_sel_isp) begin
                isp_tgl <= ~isp_tgl; // RQ16
            end
        end
    end
    assign tdo = scan_sr[0];

    // Toggle crossing; the shift register holds still until it is used
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            boot_sync <= 3'h0;
            isp_sync <= 3'h0;
        end else begin
            boot_sync <= {boot_sync[1:0], boot_tgl};
            isp_sync <= {isp_sync[1:0], isp_tgl};
        end
    end
    assign boot_load = boot_sync[2] ^ boot_sync[1];
    assign isp_start = isp_sync[2] ^ isp_sync[1];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            boot_addr <= `PFC_BOOT_WORD_ADDR; // RQ13
        end else if (boot_load) begin
            boot_addr <= scan_sr[`PFC_SR_ADDR_LSB +: 24]; // RQ14
        end
    end

    // Chain sequencing
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= PFC_RESET;
        end else if (!req_s) begin
            state <= PFC_RESET; // RQ19
        end else begin
            unique case (state)
                PFC_RESET: begin
                    // Wait for the error line as well: our own pull in reset
                    // is still in the synchroniser and would read as an error
                    if (!csel_s && stat_s) begin
                        state <= PFC_LOAD; // RQ9
                    end
                end
                PFC_LOAD: begin
                    if (cfg_frame_error || !stat_s) begin
                        state <= PFC_ERROR; // RQ3
                    end else if (cfg_data_complete) begin
                        state <= PFC_WAIT_DONE; // RQ1
                    end
                end
                PFC_WAIT_DONE: begin
                    if (cfg_frame_error || !stat_s) begin
                        state <= PFC_ERROR;
                    end else if (done_s) begin
                        state <= PFC_INIT; // RQ2
                    end
                end
                PFC_INIT: begin
                    if (init_cnt == 12'h000) begin
                        state <= PFC_USER; // RQ18
                    end
                end
                PFC_USER: begin
                end
                PFC_ERROR: begin
                    if (auto_restart_en && restart_cnt == RESTART_LAST) begin
                        state <= PFC_RESET; // RQ4
                    end
                end
            endcase
        end
    end

    // Own errors hold the error line; a neighbour's error only restarts us
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            own_err <= 1'b0;
        end else if (state != PFC_ERROR) begin
            own_err <= cfg_frame_error; // RQ3
        end
    end

    // Restart time-out; without auto restart the wait is for a reset pulse
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            restart_cnt <= 17'h00000;
        end else if (state != PFC_ERROR) begin
            restart_cnt <= 17'h00000;
        end else if (restart_cnt != RESTART_LAST) begin
            restart_cnt <= restart_cnt + 17'h00001; // RQ4
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            init_cnt <= `PFC_INIT_CYCLES - 12'h001;
        end else if (state != PFC_INIT) begin
            init_cnt <= `PFC_INIT_CYCLES - 12'h001;
        end else if (init_cnt != 12'h000) begin
            init_cnt <= init_cnt - 12'h001; // RQ18
        end
    end

    // Flash clock divider runs only while this end uses the bus
    assign bus_run = (state == PFC_LOAD) || isp_busy;
    assign phase_end = (phase == FCLK_LAST);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase <= 4'h0;
            flash_bus_clock <= 1'b0;
        end else if (!bus_run || phase_end) begin
            phase <= 4'h0; // RQ10 RQ11
            flash_bus_clock <= 1'b0;
        end else begin
            phase <= phase + 4'h1;
            flash_bus_clock <= (phase + 4'h1) >= FCLK_HALF;
        end
    end

    // In-system write through scan: one flash clock period per word
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            isp_busy <= 1'b0;
        end else if (isp_busy) begin
            isp_busy <= !phase_end;
        end else if (isp_start && state == PFC_USER && !csel_s) begin
            isp_busy <= 1'b1; // RQ16
        end
    end

    // Address and data pins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flash_addr <= 24'h000000;
            flash_data_out <= 16'h0000;
        end else if (state == PFC_RESET) begin
            flash_addr <= boot_addr; // RQ20
        end else if (state == PFC_LOAD && phase_end) begin
            flash_addr <= flash_addr + 24'h000001; // RQ20
        end else if (isp_start && !isp_busy) begin
            flash_addr <= scan_sr[`PFC_SR_ADDR_LSB +: 24];
            flash_data_out <= scan_sr[`PFC_SR_DATA_LSB +: 16];
        end
    end

    // One word taken per flash clock period
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_word <= 16'h0000;
            cfg_word_valid <= 1'b0;
        end else begin
            cfg_word_valid <= (state == PFC_LOAD) && phase_end; // RQ12
            if ((state == PFC_LOAD) && phase_end) begin
                cfg_word <= data_sync; // RQ12
            end
        end
    end

    // Bus driven only when out of reset and chain select is low
    assign flash_bus_oe = req_s && !csel_s && bus_run; // RQ7 RQ9
    assign flash_data_oe = flash_bus_oe && isp_busy;
    assign flash_ce_b = !bus_run;
    assign flash_oe_b = !(state == PFC_LOAD);
    assign flash_we_b = !isp_busy;

    // Open-drain lines only ever pull low
    assign status_line_out = 1'b0;
    assign status_line_oe = !req_s // RQ19
        || (state == PFC_ERROR && own_err); // RQ3
    assign config_complete_line_out = 1'b0;
    assign config_complete_line_oe = (state == PFC_RESET) // RQ19
        || (state == PFC_LOAD) || (state == PFC_ERROR); // RQ1

    // Next device is enabled once this one holds all its data
    assign chain_select_out_b = !((state == PFC_WAIT_DONE) // RQ17
        || (state == PFC_INIT) || (state == PFC_USER));
    assign user_mode = (state == PFC_USER);

endmodule : pfc_loader

// ---- tb/pfc_loader_properties.sv ----
// Port checks of the parallel flash configuration loader
`timescale 1ns/10ps
module pfc_loader_properties
    import pfc_pkg::*;
#(
    parameter int RESTART_CYCLES = 20
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic config_reset_req_b,
    input wire logic chain_select_in,
    input wire logic chain_select_out_b,
    input wire logic config_complete_line_in,
    input wire logic config_complete_line_oe,
    input wire logic status_line_oe,
    input wire logic flash_bus_clock,
    input wire pfc_addr_t flash_addr,
    input wire logic flash_ce_b,
    input wire logic flash_bus_oe,
    input wire logic cfg_word_valid,
    input wire logic cfg_frame_error,
    input wire logic auto_restart_en,
    input wire logic user_mode
);
    // Slack for leaving the error state and releasing the line
    localparam int LIM = RESTART_CYCLES + 16;
    logic [12:0] init_cnt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            init_cnt <= 13'h0000;
        end else if (config_complete_line_in && !user_mode) begin
            init_cnt <= init_cnt + 13'h0001;
        end else begin
            init_cnt <= 13'h0000;
        end
    end
    property p_release;
        $fell(chain_select_out_b) |-> $fell(config_complete_line_oe);
    endproperty
    a_release: assert property (p_release)
        else $error("chain enable without line release");
    property p_hiz;
        (!config_reset_req_b) [*4] |-> !flash_bus_oe;
    endproperty
    a_hiz: assert property (p_hiz)
        else $error("flash bus driven in reset");
    property p_pull;
        (!config_reset_req_b) [*4] |->
            status_line_oe && config_complete_line_oe && !user_mode;
    endproperty
    a_pull: assert property (p_pull)
        else $error("lines not pulled in reset");
    property p_owner;
        $rose(flash_bus_oe) |-> !chain_select_in;
    endproperty
    a_owner: assert property (p_owner)
        else $error("bus taken without chain select");
    property p_step;
        cfg_word_valid |-> flash_addr == $past(flash_addr) + 24'h000001;
    endproperty
    a_step: assert property (p_step)
        else $error("address not stepped by one");
    property p_pulse;
        cfg_word_valid |=> (!cfg_word_valid) [*7];
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("more than one word per flash clock");
    property p_fclk;
        @(posedge clk) disable iff (!rst_b || !config_reset_req_b)
        $rose(flash_bus_clock) |->
            flash_bus_clock [*4] ##1 (!flash_bus_clock) [*4];
    endproperty
    a_fclk: assert property (p_fclk)
        else $error("flash clock period wrong");
    property p_err;
        cfg_frame_error && !flash_ce_b |-> ##[1:3] status_line_oe;
    endproperty
    a_err: assert property (p_err)
        else $error("error line not driven");
    property p_restart;
        $rose(status_line_oe) && auto_restart_en && config_reset_req_b
            |-> ##[1:LIM] !status_line_oe;
    endproperty
    a_restart: assert property (p_restart)
        else $error("no restart after error");
    property p_init;
        $rose(user_mode) |-> init_cnt inside {[13'hC71:13'hC76]};
    endproperty
    a_init: assert property (p_init)
        else $error("user mode at wrong time");
    cover property (cfg_word_valid);
    cover property ($rose(user_mode));
    cover property ($rose(status_line_oe) && auto_restart_en);
endmodule : pfc_loader_properties

bind pfc_loader pfc_loader_properties #(
    .RESTART_CYCLES(RESTART_CYCLES)
) u_props (.*);

// ---- tb/pfc_flash_model.sv ----
// Parallel flash model answering reads with an address-derived word
`timescale 1ns/10ps
module pfc_flash_model
    import pfc_pkg::*;
(
    input wire logic clk,
    input wire pfc_addr_t addr,
    input wire logic ce_b,
    input wire logic oe_b,
    input wire logic bus_oe,
    output pfc_word_t data
);
    // Floating pins show a changing pattern, never stale data
    initial data = 16'h0000;
    always @(posedge clk) begin
        if (bus_oe && !ce_b && !oe_b) begin
            data <= addr[15:0] ^ 16'h5A3C;
        end else begin
            data <= ~data;
        end
    end
endmodule : pfc_flash_model

// ---- tb/tb.sv ----
// Testbench of the parallel flash configuration loader
`timescale 1ns/10ps
module tb
    import pfc_pkg::*;
;
    logic clk = 0, rst_b = 0, config_reset_req_b = 1, chain_select_in = 0;
    logic auto_restart_en = 1, cfg_data_complete = 0, cfg_frame_error = 0;
    logic tck = 0, tdi = 0, scan_shift = 0, scan_update = 0, tck_en = 1;
    logic scan_sel_boot = 0, scan_sel_isp = 0, flash_ready = 0, nb_rel = 0;
    logic chain_select_out_b, config_complete_line_out, tdo;
    logic config_complete_line_oe, status_line_out, status_line_oe;
    logic flash_bus_clock, flash_ce_b, flash_oe_b, flash_we_b;
    logic flash_bus_oe, flash_data_oe, cfg_word_valid, user_mode;
    logic config_complete_line_in, status_line_in;
    pfc_addr_t flash_addr, boot = 24'h010000;
    pfc_word_t flash_data_in, flash_data_out, cfg_word;
    int fails = 0, cmp_count = 0, cyc = 0, n;
    // Wired lines: a neighbour holds completion low until released
    assign config_complete_line_in = !config_complete_line_oe && nb_rel;
    assign status_line_in = !status_line_oe;
    always #2 clk = ~clk;
    always #3 tck = tck_en & ~tck;
    pfc_loader #(.RESTART_CYCLES(20)) dut (.*);
    pfc_flash_model flash (
        .clk(clk),
        .addr(flash_addr),
        .ce_b(flash_ce_b),
        .oe_b(flash_oe_b),
        .bus_oe(flash_bus_oe),
        .data(flash_data_in)
    );
    function automatic pfc_word_t exp_w(input pfc_addr_t a);
        return a[15:0] ^ 16'h5A3C;
    endfunction : exp_w
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input string s, input logic [23:0] e,
                       input logic [23:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic wait_word(input int lim);
        for (n = 0; n < lim && cfg_word_valid !== 1'b1; n++) tick(1);
        chk("word wait", 1, n < lim);
    endtask : wait_word
    task automatic first_word;
        wait_word(400);
        chk("first word", exp_w(boot), cfg_word);
        tick(1);
    endtask : first_word
    task automatic pulse_req;
        config_reset_req_b = 0;
        tick(130);
        config_reset_req_b = 1;
    endtask : pulse_req
    task automatic err_pulse;
        wait_word(16);
        cfg_frame_error = 1;
        tick(1);
        cfg_frame_error = 0;
        tick(2);
        chk("error line", 1, status_line_oe);
    endtask : err_pulse
    task automatic scan(input logic [39:0] v);
        tck_en = 1;
        for (int k = 0; k < 40; k++) begin
            @(posedge tck) #1;
            tdi = v[k];
            scan_shift = 1;
        end
        @(posedge tck) #1;
        scan_shift = 0;
        scan_update = 1;
        @(posedge tck) #1;
        scan_update = 0;
        @(posedge tck) #1;
        tck_en = 0;
        tick(20);
    endtask : scan
    task automatic t_boot;
        first_word();
        wait_word(16);
        chk("period", 24'h7, n);
        chk("next word", exp_w(boot + 24'h000001), cfg_word);
    endtask : t_boot
    task automatic t_chain;
        cfg_data_complete = 1;
        tick(1);
        cfg_data_complete = 0;
        chk("chain enable", 0, chain_select_out_b);
        chk("line release", 0, config_complete_line_oe);
        tick(50);
        chk("early user", 0, user_mode);
        nb_rel = 1;
        for (n = 0; n < 4000 && user_mode !== 1'b1; n++) tick(1);
        chk("init time", 1, n >= 3185 && n <= 3190);
    endtask : t_chain
    task automatic t_scan;
        scan_sel_isp = 1;
        scan({16'hBEEF, 24'h00ABCD});
        scan_sel_isp = 0;
        chk("isp addr", 24'h00ABCD, flash_addr);
        chk("isp data", 16'hBEEF, flash_data_out);
        chk("scan out", 1, tdo);
        scan_sel_boot = 1;
        scan({16'h0000, 24'h000123});
        scan_sel_boot = 0;
        boot = 24'h000123;
        pulse_req();
        first_word();
    endtask : t_scan
    task automatic t_errors;
        err_pulse();
        first_word();
        chk("error release", 0, status_line_oe);
        auto_restart_en = 0;
        err_pulse();
        tick(200);
        chk("error held", 1, status_line_oe);
        pulse_req();
        first_word();
    endtask : t_errors
    task automatic t_master;
        config_reset_req_b = 0;
        chain_select_in = 1;
        tick(130);
        chk("bus released", 0, flash_bus_oe);
        chk("lines low", 3, {status_line_oe, config_complete_line_oe});
        config_reset_req_b = 1;
        tick(30);
        chk("bus kept off", 0, flash_bus_oe);
        chk("flash idle", 1, flash_ce_b);
        chain_select_in = 0;
        pulse_req();
        first_word();
    endtask : t_master
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            report_and_stop();
        end
    end
    initial begin
        tick(4);
        rst_b = 1;
        tck_en = 0;
        t_boot();
        t_chain();
        t_scan();
        t_errors();
        t_master();
        report_and_stop();
    end
endmodule : tb
